// ==== common/gcsd_pkg.sv ====
// Package with register map, field positions and constants of the gauge configuration store.
package gcsd_pkg;
   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [8:0] OFS_REM_TIME   = 9'h002;
   localparam logic [8:0] OFS_DES_VOLT   = 9'h004;
   localparam logic [8:0] OFS_CYC_INIT   = 9'h00C;
   localparam logic [8:0] OFS_PACK_OPT   = 9'h028;
   localparam logic [8:0] OFS_GAUGE_OPT  = 9'h029;
   localparam logic [8:0] OFS_MISC_HI    = 9'h02A;
   localparam logic [8:0] OFS_DFILT      = 9'h02C;
   localparam logic [8:0] OFS_DES_CAP    = 9'h032;
   localparam logic [8:0] OFS_FCC_INIT   = 9'h036;
   localparam logic [8:0] OFS_CYC_THR    = 9'h037;
   localparam logic [8:0] OFS_CHG_EFF    = 9'h054;
   localparam logic [8:0] OFS_SNS_GAIN   = 9'h0CB;
   localparam logic [8:0] OFS_CC_GAIN    = 9'h0CD;
   localparam logic [8:0] OFS_CC_OFS     = 9'h0D2;
   localparam logic [8:0] OFS_GND_OFS    = 9'h0D4;
   localparam logic [8:0] OFS_ADC_OFS    = 9'h0D5;
   localparam logic [8:0] OFS_CTRL       = 9'h180;
   localparam logic [8:0] OFS_STATUS     = 9'h181;
   localparam logic [8:0] OFS_CAP_RPT    = 9'h182;
   localparam logic [8:0] OFS_CYC_CNT    = 9'h183;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int PK_VIEW = 7;
   localparam int PK_LED1 = 6;
   localparam int PK_LED0 = 5;
   localparam int PK_HPEC = 4;
   localparam int PK_CPEC = 3;
   localparam int PK_BINH = 2;
   localparam int PK_CC1  = 1;
   localparam int PK_CC0  = 0;
   localparam int GG_SYNC = 6;
   localparam int GG_CTYP = 5;
   localparam int GG_COMP = 4;
   localparam int GG_EODS = 3;
   localparam int GG_OVS  = 2;
   localparam int GG_CONTINUOUS_MIDRANGE_FIX = 1;
   localparam int GG_ONCE = 0;
   localparam int MH_FEC  = 5;
   localparam int MH_SLP  = 4;
   localparam int MH_OT   = 3;
   localparam int CT_MWH  = 0;
   localparam int PF_FE_BIT = 3;
   // Fixed-value bits of the option bytes.
   localparam logic [7:0] GAUGE_FIX_MASK = 8'h80;
   localparam logic [7:0] GAUGE_FIX_VAL  = 8'h00;
   localparam logic [7:0] MISC_FIX_MASK  = 8'h42;
   localparam logic [7:0] MISC_FIX_VAL   = 8'h02;
   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [15:0] SNS_GAIN_RST  = 16'h3BD0;
   localparam logic [31:0] CC_GAIN_RST   = 32'h920A1600;
   localparam logic [15:0] CC_OFS_RST    = 16'hC225;
   localparam logic [7:0]  OFS8_RST      = 8'h26;
   localparam logic [7:0]  PACK_RST      = 8'h00;
   localparam logic [7:0]  GAUGE_RST     = 8'h00;
   localparam logic [7:0]  MISC_RST      = 8'h02;
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          SLEEP_IDLE_S  = 2;
   localparam int          SLEEP_CYCLES  = SLEEP_IDLE_S * CLK_HZ;
   localparam int          FILTER_NV_PER = 290;
   // ------------------------------------------------------------------
   // Decoded configuration carrier
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       led_charge_view_select;
      logic [2:0] led_count;
      logic       host_pec_enable;
      logic       charger_pec_enable;
      logic       broadcast_enable;
      logic [2:0] series_cells;
      logic       termination_sync;
      logic       charger_type_select;
      logic       eod_compensation_enable;
      logic       eod_source_select;
      logic       overvoltage_source_select;
      logic       continuous_midrange_fix;
      logic       single_midrange_fix;
      logic       front_end_check_enable;
   } gcsd_cfg_s;
endpackage

// ==== design/gcsd_top.sv ====
// Configuration store, option decode and derived gauge quantities.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Integrator results are scaled to mAh by the 16-bit sense gain.
// - Coulomb count is multiplied by the 32-bit gain factor.
// - Three offsets are rewritten on sleep conditions before sleep entry.
// - Filter threshold equals stored value times 290 nV.
// - Design capacity reported direct in mAh, times voltage/10000 in mWh mode.
// - Alarm thresholds come from stored time and capacity values.
// - Cycle count increments when discharged charge reaches the threshold.
// - Added charge is weighted by (code+1)/256.
// - Pack bit 7 selects relative or absolute charge for LEDs.
// - LED field: 00 and 11 five, 01 three, 10 four LEDs.
// - PEC bits add PEC to host alarms and charger broadcasts.
// - Broadcast inhibit stops broadcasts; mode writes cannot re-enable them.
// - Cell field: 11 four, 10 three, 01 two series cells.
// - Termination sync loads remaining capacity with a percentage of full capacity.
// - Charger type bit selects learning optimisation.
// - Compensation bit selects computed or fixed end-of-discharge thresholds.
// - Source bit selects pack voltage or lowest cell voltage for EOD.
// - Overvoltage uses pack voltage or highest cell times cell count.
// - Midrange correction continuous, or once after reset.
// - Front-end check enables failure flag with failure config bit 3.
// - Sleep after 2 s of bus low unless sleep disabled.
// - Overtemperature turns off charge FET, and discharge FET if enabled.
module gcsd_top #(
   parameter int SLEEP_CYC = gcsd_pkg::SLEEP_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Register port
   input  wire logic [8:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata,
   // Measurement inputs
   input  wire logic [15:0] conv_result,
   input  wire logic        conv_valid,
   input  wire logic [15:0] cal_coulomb_offset,
   input  wire logic [7:0]  cal_gnd_offset,
   input  wire logic [7:0]  cal_adc_offset,
   input  wire logic        sleep_cond,
   input  wire logic        smbus_clk_pin,
   input  wire logic        overtemp,
   input  wire logic        fe_comm_error,
   input  wire logic [7:0]  pf_config,
   input  wire logic        charge_term,
   input  wire logic        alarm_req,
   input  wire logic        mode_broadcast_req,
   input  wire logic [15:0] discharged_mah,
   input  wire logic [15:0] charge_in,
   input  wire logic [15:0] remaining_time,
   input  wire logic [15:0] remaining_cap,
   // Derived outputs
   output var  logic [31:0] scaled_charge,
   output var  logic [15:0] weighted_charge,
   output var  logic [15:0] filter_thr_nv,
   output var  logic        time_alarm,
   output var  logic        cap_alarm,
   output var  gcsd_pkg::gcsd_cfg_s cfg,
   output var  logic        sleep_enter,
   output var  logic        chg_fet_off,
   output var  logic        dsg_fet_off,
   output var  logic        fe_fail,
   output var  logic        host_alarm_send,
   output var  logic        charger_send,
   output var  logic        term_load,
   output var  logic        once_fix_req
);
   import gcsd_pkg::*;
   // Checks without their own clock sample on the rising edge and rest while reset is high.
   default clocking chk_cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // Store registers
   // ------------------------------------------------------------------
   logic [15:0] rem_time_reg, des_volt_reg, cyc_init_reg, des_cap_reg, fcc_reg;
   logic [15:0] cyc_thr_reg, sns_gain_reg, cc_ofs_reg, rem_cap_thr_reg;
   logic [31:0] cc_gain_reg;
   logic [7:0]  pack_reg, gauge_reg, misc_reg, dfilt_reg, eff_reg, gnd_ofs_reg, adc_ofs_reg;
   logic        mwh_mode_reg;
   logic [15:0] cycle_cnt_reg;
   logic [15:0] cap_rpt_reg;
   logic        sleep_sync1_reg, sleep_sync2_reg;
   logic [31:0] idle_cnt_reg;
   logic        once_done_reg;
   logic        wr_cyc_init;

   assign wr_cyc_init = reg_wr && reg_addr == OFS_CYC_INIT;

   // Offsets are overwritten by calibration on sleep conditions, which wins over software.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cc_ofs_reg  <= CC_OFS_RST;
         gnd_ofs_reg <= OFS8_RST;
         adc_ofs_reg <= OFS8_RST;
      end else if (sleep_cond) begin
         cc_ofs_reg  <= cal_coulomb_offset;
         gnd_ofs_reg <= cal_gnd_offset;
         adc_ofs_reg <= cal_adc_offset;
      end else if (reg_wr) begin
         if (reg_addr == OFS_CC_OFS) cc_ofs_reg <= reg_wdata[15:0];
         if (reg_addr == OFS_GND_OFS) gnd_ofs_reg <= reg_wdata[7:0];
         if (reg_addr == OFS_ADC_OFS) adc_ofs_reg <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rem_time_reg    <= 16'h0000;
         des_volt_reg    <= 16'h0000;
         cyc_init_reg    <= 16'h0000;
         des_cap_reg     <= 16'h0000;
         fcc_reg         <= 16'h0000;
         cyc_thr_reg     <= 16'h0000;
         sns_gain_reg    <= SNS_GAIN_RST;
         cc_gain_reg     <= CC_GAIN_RST;
         pack_reg        <= PACK_RST;
         gauge_reg       <= GAUGE_RST;
         misc_reg        <= MISC_RST;
         dfilt_reg       <= 8'h00;
         eff_reg         <= 8'h00;
         mwh_mode_reg    <= 1'b0;
         rem_cap_thr_reg <= 16'h0000;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_REM_TIME:  rem_time_reg <= reg_wdata[15:0];
            OFS_DES_VOLT:  des_volt_reg <= reg_wdata[15:0];
            OFS_CYC_INIT:  cyc_init_reg <= reg_wdata[15:0];
            OFS_DES_CAP:   des_cap_reg <= reg_wdata[15:0];
            OFS_FCC_INIT:  fcc_reg <= reg_wdata[15:0];
            OFS_CYC_THR:   cyc_thr_reg <= reg_wdata[15:0];
            OFS_SNS_GAIN:  sns_gain_reg <= reg_wdata[15:0];
            OFS_CC_GAIN:   cc_gain_reg <= reg_wdata;
            OFS_PACK_OPT:  pack_reg <= reg_wdata[7:0];
            OFS_GAUGE_OPT: gauge_reg <= (reg_wdata[7:0] & ~GAUGE_FIX_MASK) | GAUGE_FIX_VAL;
            OFS_MISC_HI:   misc_reg <= (reg_wdata[7:0] & ~MISC_FIX_MASK) | MISC_FIX_VAL;
            OFS_DFILT:     dfilt_reg <= reg_wdata[7:0];
            OFS_CHG_EFF:   eff_reg <= reg_wdata[7:0];
            OFS_CTRL: begin
               mwh_mode_reg    <= reg_wdata[CT_MWH];
               rem_cap_thr_reg <= reg_wdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_REM_TIME:  reg_rdata <= {16'h0000, rem_time_reg};
            OFS_DES_VOLT:  reg_rdata <= {16'h0000, des_volt_reg};
            OFS_CYC_INIT:  reg_rdata <= {16'h0000, cyc_init_reg};
            OFS_DES_CAP:   reg_rdata <= {16'h0000, des_cap_reg};
            OFS_FCC_INIT:  reg_rdata <= {16'h0000, fcc_reg};
            OFS_CYC_THR:   reg_rdata <= {16'h0000, cyc_thr_reg};
            OFS_SNS_GAIN:  reg_rdata <= {16'h0000, sns_gain_reg};
            OFS_CC_GAIN:   reg_rdata <= cc_gain_reg;
            OFS_CC_OFS:    reg_rdata <= {16'h0000, cc_ofs_reg};
            OFS_GND_OFS:   reg_rdata <= {24'h000000, gnd_ofs_reg};
            OFS_ADC_OFS:   reg_rdata <= {24'h000000, adc_ofs_reg};
            OFS_PACK_OPT:  reg_rdata <= {24'h000000, pack_reg};
            OFS_GAUGE_OPT: reg_rdata <= {24'h000000, gauge_reg};
            OFS_MISC_HI:   reg_rdata <= {24'h000000, misc_reg};
            OFS_DFILT:     reg_rdata <= {24'h000000, dfilt_reg};
            OFS_CHG_EFF:   reg_rdata <= {24'h000000, eff_reg};
            OFS_CTRL:      reg_rdata <= {rem_cap_thr_reg, 15'h0000, mwh_mode_reg};
            OFS_STATUS:    reg_rdata <= {28'h0000000, fe_fail, once_done_reg, sleep_enter, chg_fet_off};
            OFS_CAP_RPT:   reg_rdata <= {16'h0000, cap_rpt_reg};
            OFS_CYC_CNT:   reg_rdata <= {16'h0000, cycle_cnt_reg};
            default:       reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // Arithmetic on measurements
   // ------------------------------------------------------------------
   logic [47:0] cc_prod;
   logic [31:0] sns_prod;
   logic [23:0] eff_prod;
   logic [31:0] cap_prod;
   assign sns_prod = conv_result * sns_gain_reg;
   assign cc_prod  = sns_prod * cc_gain_reg;
   assign eff_prod = charge_in * ({8'h00, eff_reg} + 16'h0001);
   assign cap_prod = des_cap_reg * des_volt_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         scaled_charge   <= 32'h0000_0000;
         weighted_charge <= 16'h0000;
      end else if (conv_valid) begin
         scaled_charge   <= cc_prod[47:16];
         weighted_charge <= eff_prod[23:8];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         filter_thr_nv <= 16'h0000;
         cap_rpt_reg   <= 16'h0000;
         time_alarm    <= 1'b0;
         cap_alarm     <= 1'b0;
      end else begin
         filter_thr_nv <= 16'(dfilt_reg * 16'(FILTER_NV_PER));
         cap_rpt_reg   <= mwh_mode_reg ? 16'(cap_prod / 32'h0000_2710) : des_cap_reg;
         time_alarm    <= rem_time_reg != 16'h0000 && remaining_time < rem_time_reg;
         cap_alarm     <= rem_cap_thr_reg != 16'h0000 && remaining_cap < rem_cap_thr_reg;
      end
   end

   // Cycle counter: increments each time accumulated discharge reaches the threshold.
   logic [15:0] dis_acc_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         cycle_cnt_reg <= 16'h0000;
         dis_acc_reg   <= 16'h0000;
      end else if (wr_cyc_init) begin
         cycle_cnt_reg <= reg_wdata[15:0];
         dis_acc_reg   <= 16'h0000;
      end else if (cyc_thr_reg != 16'h0000 && discharged_mah - dis_acc_reg >= cyc_thr_reg) begin
         cycle_cnt_reg <= cycle_cnt_reg + 16'h0001;
         dis_acc_reg   <= dis_acc_reg + cyc_thr_reg;
      end
   end

   // ------------------------------------------------------------------
   // Option decode
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg <= '0;
      end else begin
         cfg.led_charge_view_select <= pack_reg[PK_VIEW];
         unique case ({pack_reg[PK_LED1], pack_reg[PK_LED0]})
            2'b01:   cfg.led_count <= 3'h3;
            2'b10:   cfg.led_count <= 3'h4;
            default: cfg.led_count <= 3'h5;
         endcase
         cfg.host_pec_enable    <= pack_reg[PK_HPEC];
         cfg.charger_pec_enable <= pack_reg[PK_CPEC];
         cfg.broadcast_enable   <= ~pack_reg[PK_BINH];
         unique case ({pack_reg[PK_CC1], pack_reg[PK_CC0]})
            2'b11:   cfg.series_cells <= 3'h4;
            2'b10:   cfg.series_cells <= 3'h3;
            default: cfg.series_cells <= 3'h2;
         endcase
         cfg.termination_sync          <= gauge_reg[GG_SYNC];
         cfg.charger_type_select       <= gauge_reg[GG_CTYP];
         cfg.eod_compensation_enable   <= gauge_reg[GG_COMP];
         cfg.eod_source_select         <= gauge_reg[GG_EODS];
         cfg.overvoltage_source_select <= gauge_reg[GG_OVS];
         cfg.continuous_midrange_fix   <= gauge_reg[GG_CONTINUOUS_MIDRANGE_FIX];
         cfg.single_midrange_fix       <= gauge_reg[GG_ONCE];
         cfg.front_end_check_enable    <= misc_reg[MH_FEC];
      end
   end

   // Messages are gated only by the pack byte, so mode broadcasts cannot bypass the inhibit.
   always_ff @(posedge mclk) begin
      if (rst) begin
         host_alarm_send <= 1'b0;
         charger_send    <= 1'b0;
         term_load       <= 1'b0;
      end else begin
         host_alarm_send <= alarm_req && !pack_reg[PK_BINH];
         charger_send    <= mode_broadcast_req && !pack_reg[PK_BINH];
         term_load       <= charge_term && gauge_reg[GG_SYNC];
      end
   end

   // ------------------------------------------------------------------
   // Sleep, front end, thermal and one-time correction
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         sleep_sync1_reg <= 1'b1;
         sleep_sync2_reg <= 1'b1;
      end else begin
         sleep_sync1_reg <= smbus_clk_pin;
         sleep_sync2_reg <= sleep_sync1_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         idle_cnt_reg <= 32'h0000_0000;
         sleep_enter  <= 1'b0;
      end else if (sleep_sync2_reg || misc_reg[MH_SLP]) begin
         idle_cnt_reg <= 32'h0000_0000;
         sleep_enter  <= 1'b0;
      end else if (idle_cnt_reg >= 32'(SLEEP_CYC - 1)) begin
         sleep_enter <= 1'b1;
      end else begin
         idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         chg_fet_off   <= 1'b0;
         dsg_fet_off   <= 1'b0;
         fe_fail       <= 1'b0;
         once_done_reg <= 1'b0;
         once_fix_req  <= 1'b0;
      end else begin
         chg_fet_off <= overtemp;
         dsg_fet_off <= overtemp && misc_reg[MH_OT];
         if (fe_comm_error && misc_reg[MH_FEC] && pf_config[PF_FE_BIT]) fe_fail <= 1'b1;
         once_fix_req <= gauge_reg[GG_ONCE] && !once_done_reg;
         if (gauge_reg[GG_ONCE]) once_done_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   offset_cal_a: assert property (@(posedge mclk) disable iff (rst) sleep_cond |=> cc_ofs_reg == $past(cal_coulomb_offset))
      else $error("offset not recalibrated");
   dsg_fet_a: assert property (@(posedge mclk) disable iff (rst) dsg_fet_off |-> chg_fet_off)
      else $error("discharge fet off without charge fet off");
   fet_follow_a: assert property (@(posedge mclk) disable iff (rst) overtemp |=> chg_fet_off)
      else $error("charge fet not off on overtemp");
   bcast_inh_a: assert property (@(posedge mclk) disable iff (rst) pack_reg[PK_BINH] |=> !charger_send && !host_alarm_send)
      else $error("broadcast while inhibited");
   sleep_dis_a: assert property (@(posedge mclk) disable iff (rst) misc_reg[MH_SLP] |=> !sleep_enter)
      else $error("sleep while disabled");
   fix_bits_a: assert property (@(posedge mclk) disable iff (rst) (misc_reg & MISC_FIX_MASK) == MISC_FIX_VAL && !gauge_reg[7])
      else $error("fixed option bit changed");
   led_count_a: assert property (@(posedge mclk) disable iff (rst) pack_reg[6:5] == 2'b01 ##1 pack_reg[6:5] == 2'b01 |-> cfg.led_count == 3'h3)
      else $error("wrong led count");
   cycle_inc_a: assert property (@(posedge mclk) disable iff (rst) !wr_cyc_init ##1 !$past(wr_cyc_init) |-> cycle_cnt_reg - $past(cycle_cnt_reg) <= 16'h0001)
      else $error("cycle count jumped");
   fe_fail_a: assert property (@(posedge mclk) disable iff (rst) $rose(fe_fail) |-> $past(misc_reg[MH_FEC]) && $past(pf_config[PF_FE_BIT]))
      else $error("front end fail without enable");
   // Decoded fields must follow the stored bytes one cycle later.
   led_view_a: assert property (cfg.led_charge_view_select |-> $past(pack_reg[PK_VIEW]))
      else $error("led view not from pack byte");
   cell_count_a: assert property (&pack_reg[1:0] ##1 &pack_reg[1:0] |-> cfg.series_cells == 3'h4)
      else $error("wrong series cell count");
   bcast_cfg_a: assert property (cfg.broadcast_enable |-> !$past(pack_reg[PK_BINH]))
      else $error("broadcast enabled while inhibited");
   term_sync_a: assert property (term_load |-> $past(gauge_reg[GG_SYNC] && charge_term))
      else $error("capacity load without sync");
   once_pulse_a: assert property (once_fix_req |=> !once_fix_req)
      else $error("one-time correction repeated");
   fe_sticky_a: assert property (fe_fail |=> fe_fail)
      else $error("front end fail dropped");
   // Thermal and sleep outputs react to the inputs of the previous cycle.
   dsg_ot_a: assert property (overtemp && misc_reg[MH_OT] |=> dsg_fet_off)
      else $error("discharge fet left on");
   chg_clear_a: assert property (!overtemp |=> !chg_fet_off)
      else $error("charge fet off without overtemp");
   sleep_cause_a: assert property ($rose(sleep_enter) |-> !$past(sleep_sync2_reg) && !$past(misc_reg[MH_SLP]))
      else $error("sleep without bus low");
   sleep_time_a: assert property ($rose(sleep_enter) |-> $past(idle_cnt_reg) >= 32'(SLEEP_CYC - 1))
      else $error("sleep entered early");
   // Alarms, capacity report and counters against their stored thresholds.
   time_alarm_a: assert property (time_alarm |-> $past(remaining_time) < $past(rem_time_reg))
      else $error("time alarm above threshold");
   cap_alarm_a: assert property (cap_alarm |-> $past(remaining_cap) < $past(rem_cap_thr_reg))
      else $error("capacity alarm above threshold");
   cap_direct_a: assert property (!mwh_mode_reg |=> cap_rpt_reg == $past(des_cap_reg))
      else $error("capacity not reported direct");
   cyc_source_a: assert property (!$past(wr_cyc_init) && cycle_cnt_reg != $past(cycle_cnt_reg) |-> $past(cyc_thr_reg) != 16'h0000)
      else $error("cycle count moved without threshold");
   gnd_cal_a: assert property (sleep_cond |=> gnd_ofs_reg == $past(cal_gnd_offset) && adc_ofs_reg == $past(cal_adc_offset))
      else $error("8-bit offsets not recalibrated");
endmodule
`default_nettype wire

// ==== verif/gauge_config_store_decode_tb.sv ====
// Self-checking bench of the gauge configuration store.
`timescale 1ns/10ps
`default_nettype none
module gauge_config_store_decode_tb;
   import gcsd_pkg::*;
   logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, conv_valid = 0, sleep_cond = 0, overtemp = 0;
   logic fe_comm_error = 0, charge_term = 0, hold_low = 0, send_req = 0;
   logic smbus_clk_pin, alarm_req, mode_broadcast_req, time_alarm, cap_alarm, sleep_enter;
   logic chg_fet_off, dsg_fet_off, fe_fail, host_alarm_send, charger_send, term_load, once_fix_req;
   logic [8:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, scaled_charge, seed = 32'hd85ac838, d, g;
   logic [15:0] conv_result = 0, cal_coulomb_offset = 0, discharged_mah = 0, charge_in = 0, a, b;
   logic [15:0] remaining_time = 0, remaining_cap = 0, weighted_charge, filter_thr_nv;
   logic [7:0] cal_gnd_offset = 0, cal_adc_offset = 0, pf_config = 0, e;
   logic [1:0] c;
   gcsd_cfg_s cfg;
   int n_mismatch = 0, n_tests = 0, cyc = 0, n_once = 0;
   gcsd_top #(.SLEEP_CYC(50)) i_gcsd_top (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .conv_result, .conv_valid, .cal_coulomb_offset, .cal_gnd_offset, .cal_adc_offset,
      .sleep_cond, .smbus_clk_pin, .overtemp, .fe_comm_error, .pf_config, .charge_term, .alarm_req,
      .mode_broadcast_req, .discharged_mah, .charge_in, .remaining_time, .remaining_cap,
      .scaled_charge, .weighted_charge, .filter_thr_nv, .time_alarm, .cap_alarm, .cfg, .sleep_enter,
      .chg_fet_off, .dsg_fet_off, .fe_fail, .host_alarm_send, .charger_send, .term_load, .once_fix_req);
   gcsd_host_model i_gcsd_host_model (.mclk, .rst, .hold_low, .send_req, .smbus_clk_pin, .alarm_req,
      .mode_broadcast_req);
   always #5 mclk = ~mclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic w(input logic [8:0] ad, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [8:0] ad, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk) begin
      if (once_fix_req === 1'b1) n_once++;
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      tick(16);
      rst <= 1'b0;
      rc(OFS_SNS_GAIN, 32'(SNS_GAIN_RST));
      rc(OFS_CC_GAIN, CC_GAIN_RST);
      rc(OFS_CC_OFS, 32'(CC_OFS_RST));
      rc(OFS_ADC_OFS, 32'(OFS8_RST));
      rc(9'h1FF, 32'h0);
      w(OFS_GAUGE_OPT, 32'hFF);
      rc(OFS_GAUGE_OPT, 32'h7F);
      w(OFS_MISC_HI, 32'hFF);
      rc(OFS_MISC_HI, 32'hBF);
      pf_config <= 8'h08;
      fe_comm_error <= 1'b1;
      overtemp <= 1'b1;
      hold_low <= 1'b1;
      tick(70);
      chk(32'({cfg.front_end_check_enable, fe_fail, chg_fet_off, dsg_fet_off, sleep_enter}), 32'h1E);
      hold_low <= 1'b0;
      fe_comm_error <= 1'b0;
      w(OFS_MISC_HI, 32'h0);
      tick(3);
      chk(32'({fe_fail, chg_fet_off, dsg_fet_off}), 32'h6);
      hold_low <= 1'b1;
      tick(45);
      chk(32'(sleep_enter), 32'h0);
      tick(15);
      chk(32'(sleep_enter), 32'h1);
      hold_low <= 1'b0;
      overtemp <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         w(OFS_PACK_OPT, 32'({c[0], c, c, c[0], c}));
         tick(3);
         chk(32'({cfg.led_charge_view_select, cfg.host_pec_enable, cfg.charger_pec_enable}), 32'({c[0], c}));
         chk(32'(cfg.broadcast_enable), 32'(!c[0]));
         chk(32'(cfg.led_count), c == 1 ? 3 : c == 2 ? 4 : 5);
         chk(32'(cfg.series_cells), c == 3 ? 4 : c == 2 ? 3 : 2);
         send_req <= 1'b1;
         tick(1);
         send_req <= 1'b0;
         tick(1);
         chk(32'({host_alarm_send, charger_send}), c[0] ? 0 : 3);
      end
      d = $random(seed) | 32'h40;
      w(OFS_GAUGE_OPT, d & 32'hFF);
      tick(3);
      chk(32'(cfg[7:1]), d & 32'h7F);
      charge_term <= 1'b1;
      tick(1);
      charge_term <= 1'b0;
      chk(32'(term_load), 32'h1);
      a = 16'($random(seed));
      b = 16'($random(seed));
      g = $random(seed);
      e = 8'($random(seed));
      w(OFS_SNS_GAIN, 32'(a));
      w(OFS_CC_GAIN, g);
      w(OFS_CHG_EFF, 32'(e));
      w(OFS_DFILT, 32'(e));
      conv_result <= b;
      charge_in <= a;
      conv_valid <= 1'b1;
      tick(1);
      conv_valid <= 1'b0;
      tick(1);
      chk(scaled_charge, 32'((64'(b) * a * g) >> 16));
      chk(32'(weighted_charge), (32'(a) * (e + 1)) >> 8);
      chk(32'(filter_thr_nv), 32'(16'(e * 290)));
      w(OFS_DES_CAP, 32'(a));
      w(OFS_DES_VOLT, 32'(b));
      rc(OFS_CAP_RPT, 32'(a));
      w(OFS_CTRL, {16'd500, 16'h1});
      rc(OFS_CAP_RPT, 32'(16'(64'(a) * b / 10000)));
      w(OFS_REM_TIME, 32'd10);
      remaining_time <= 16'd10;
      remaining_cap <= 16'd499;
      tick(3);
      chk(32'({time_alarm, cap_alarm}), 32'h1);
      remaining_time <= 16'h0009;
      remaining_cap <= 16'h01F4;
      tick(3);
      chk(32'({time_alarm, cap_alarm}), 32'h2);
      w(OFS_CYC_THR, 32'd100);
      w(OFS_CYC_INIT, 32'd5);
      discharged_mah <= 16'd99;
      tick(3);
      rc(OFS_CYC_CNT, 32'd5);
      discharged_mah <= 16'd100;
      tick(3);
      rc(OFS_CYC_CNT, 32'd6);
      cal_coulomb_offset <= a;
      cal_gnd_offset <= e;
      cal_adc_offset <= ~e;
      sleep_cond <= 1'b1;
      tick(2);
      sleep_cond <= 1'b0;
      rc(OFS_CC_OFS, 32'(a));
      rc(OFS_GND_OFS, 32'(e));
      rc(OFS_ADC_OFS, {24'h000000, ~e});
      rc(OFS_STATUS, 32'hC);
      chk(32'(n_once), 32'h1);
      print_verdict;
   end
endmodule
`default_nettype wire

// ==== verif/gcsd_host_model.sv ====
// Stand-in for the host and charger: SMBus clock and alarm requests.
`timescale 1ns/10ps
`default_nettype none
module gcsd_host_model (
   // Clock, reset and bench control
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic hold_low,
   input  wire logic send_req,
   // SMBus side
   output var  logic smbus_clk_pin,
   output var  logic alarm_req,
   output var  logic mode_broadcast_req
);
   // The bus clock toggles while active and is held low when idle is asked for.
   always_ff @(posedge mclk) begin
      if (rst) begin
         smbus_clk_pin <= 1'b1;
      end else begin
         smbus_clk_pin <= ~hold_low & ~smbus_clk_pin;
      end
   end
   always_ff @(posedge mclk) begin
      alarm_req          <= send_req;
      mode_broadcast_req <= send_req;
   end
endmodule
`default_nettype wire
